// ### src/bcr_pkg.sv
// Package for the blink code fault reporter: fault codes, classes, timing.
// Assumes a single 125 MHz module clock.
`default_nettype none
package bcr_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   // Acknowledge deadline in ms and its cycle count
   localparam int unsigned ACK_TMO_MS = 400;
   localparam longint unsigned ACK_TMO_CYC_L =
      longint'(ACK_TMO_MS) * longint'(CLK_HZ) / 64'd1000;
   localparam int unsigned ACK_TMO_CYC = int'(ACK_TMO_CYC_L);
   // Blink half period and pause, in ms
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned BLINK_HALF_CYC_D =
      int'(longint'(BLINK_HALF_MS) * longint'(CLK_HZ) / 64'd1000);
   localparam int unsigned PAUSE_MS = 1500;
   localparam int unsigned PAUSE_CYC_D =
      int'(longint'(PAUSE_MS) * longint'(CLK_HZ) / 64'd1000);

   localparam logic [4:0] PORT_MAX = 5'h15;
   localparam logic [4:0] PORT_EXEMPT = 5'h09;
   localparam logic [15:0] RAM_MIN_KB = 16'h0008;

   localparam logic [11:0] C_PWRDN = 12'h014;
   localparam logic [11:0] C_RAMSEQ = 12'h815;
   localparam logic [11:0] C_ACKTMO = 12'h056;
   localparam logic [11:0] C_LOOP1 = 12'h617;
   localparam logic [11:0] C_PARITY = 12'h618;
   localparam logic [11:0] C_PORTBIG = 12'h619;
   localparam logic [11:0] C_RAMSMALL = 12'h61A;
   localparam logic [11:0] C_UNDER = 12'h627;
   localparam logic [11:0] C_NOCOMPL = 12'h639;
   localparam logic [11:0] C_PRIV = 12'h691;
   localparam logic [11:0] C_SLVTMO = 12'h6A4;
   localparam logic [11:0] C_RAMADDR = 12'h513;
   localparam logic [11:0] C_RAMDATA = 12'h412;
   localparam logic [11:0] C_PROM = 12'h311;

   // Blink counts; zero means steady light
   localparam logic [2:0] BL_STEADY = 3'h0;
   localparam logic [2:0] BL_TWO = 3'h2;
   localparam logic [2:0] BL_THREE = 3'h3;
   localparam logic [2:0] BL_FOUR = 3'h4;
   localparam logic [2:0] BL_FIVE = 3'h5;
   localparam logic [2:0] BL_SIX = 3'h6;
   localparam logic [2:0] BL_SEVEN = 3'h7;

   localparam int NSRC = 14;

   typedef enum logic [3:0] {
      BST_IDLE = 4'h1,
      BST_ON = 4'h2,
      BST_OFF = 4'h4,
      BST_PAUSE = 4'h8
   } bcr_bst_t;
endpackage
`default_nettype wire

// ### src/bcr_reporter.sv
// Fault reporter: latches the first fault code, blinks the run light,
// duplicates network traffic on two ports and steers the bridge path.
// Assumes synchronous inputs and one clock domain.
`default_nettype none
// How it works
// - Latch fault hex code, blink its class
// - Power-down: steady run light, code 014H
// - Self-test: 5/6/7 blinks for 513/412/311H
// - No ack within 400 ms raises 56H
// - Serial faults 617/618/627H, four blinks
// - Port setting above 21 gives 619H
// - Controller RAM below 8k gives 61AH
// - Peer reply not complement gives 639H
// - Slave timeout off port 9 gives 6A4H
// - Privilege still set after session: 691H
// - Same traffic both ports, record path
// - Bridge serial to network or local
// - Ready only after diagnostics pass
module bcr_reporter
   import bcr_pkg::*;
#(
   parameter int unsigned ACK_CYC = ACK_TMO_CYC,
   parameter int unsigned HALF_CYC = BLINK_HALF_CYC_D,
   parameter int unsigned PAUSE_CYC = PAUSE_CYC_D
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic pwrdn_i,
   input wire logic ramseq_err_i,
   input wire logic ramaddr_err_i,
   input wire logic ramdata_err_i,
   input wire logic prom_err_i,
   input wire logic diag_done_i,
   input wire logic req_i,
   input wire logic ack_i,
   input wire logic loop1_err_i,
   input wire logic parity_err_i,
   input wire logic underflow_i,
   input wire logic port_set_i,
   input wire logic [4:0] port_num_i,
   input wire logic ram_size_vld_i,
   input wire logic [15:0] ram_kb_i,
   input wire logic op_sent_i,
   input wire logic [7:0] op_i,
   input wire logic reply_vld_i,
   input wire logic [7:0] reply_i,
   input wire logic slv_tmo_i,
   input wire logic [4:0] slv_port_i,
   input wire logic sess_done_i,
   input wire logic priv_flag_i,
   input wire logic tx_vld_i,
   input wire logic [7:0] tx_data_i,
   input wire logic rx_a_vld_i,
   input wire logic rx_b_vld_i,
   input wire logic bridge_en_i,
   input wire logic ser_vld_i,
   input wire logic ser_to_local_i,
   input wire logic [7:0] ser_data_i,
   output logic run_led_o,
   output logic ready_led_o,
   output logic fault_o,
   output logic [11:0] fault_code_o,
   output logic [2:0] fault_blinks_o,
   output logic net_a_vld_o,
   output logic net_b_vld_o,
   output logic [7:0] net_a_data_o,
   output logic [7:0] net_b_data_o,
   output logic [1:0] rx_path_o,
   output logic loc_vld_o,
   output logic [7:0] loc_data_o
);
   ////////////////////////////////////////////////////////////////////////
   // Fault sources, lowest index has priority
   logic [NSRC-1:0] src;
   logic [11:0] codes [NSRC];
   logic [2:0] blinks [NSRC];
   logic [31:0] ack_cnt_r;
   logic ack_wait_r;
   logic [7:0] op_r;
   logic op_pend_r;
   logic ack_tmo;

   assign ack_tmo = ack_wait_r && !ack_i && (ack_cnt_r >= ACK_CYC - 1);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_wait_r <= 1'b0;
         ack_cnt_r <= '0;
      end else if (ce_i) begin
         if (ack_wait_r && (ack_i || ack_tmo)) begin
            ack_wait_r <= 1'b0;
            ack_cnt_r <= '0;
         end else if (req_i && !ack_wait_r) begin
            ack_wait_r <= 1'b1;
            ack_cnt_r <= '0;
         end else if (ack_wait_r) begin
            ack_cnt_r <= ack_cnt_r + 32'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         op_r <= 8'h00;
         op_pend_r <= 1'b0;
      end else if (ce_i) begin
         if (op_sent_i) begin
            op_r <= op_i;
            op_pend_r <= 1'b1;
         end else if (reply_vld_i) begin
            op_pend_r <= 1'b0;
         end
      end
   end

   assign src[0] = pwrdn_i;
   assign codes[0] = C_PWRDN;
   assign blinks[0] = BL_STEADY;
   assign src[1] = ramseq_err_i;
   assign codes[1] = C_RAMSEQ;
   assign blinks[1] = BL_TWO;
   assign src[2] = ramaddr_err_i;
   assign codes[2] = C_RAMADDR;
   assign blinks[2] = BL_FIVE;
   assign src[3] = ramdata_err_i;
   assign codes[3] = C_RAMDATA;
   assign blinks[3] = BL_SIX;
   assign src[4] = prom_err_i;
   assign codes[4] = C_PROM;
   assign blinks[4] = BL_SEVEN;
   assign src[5] = ack_tmo;
   assign codes[5] = C_ACKTMO;
   assign blinks[5] = BL_THREE;
   assign src[6] = loop1_err_i;
   assign codes[6] = C_LOOP1;
   assign blinks[6] = BL_FOUR;
   assign src[7] = parity_err_i;
   assign codes[7] = C_PARITY;
   assign blinks[7] = BL_FOUR;
   assign src[8] = underflow_i;
   assign codes[8] = C_UNDER;
   assign blinks[8] = BL_FOUR;
   assign src[9] = port_set_i && (port_num_i > PORT_MAX);
   assign codes[9] = C_PORTBIG;
   assign blinks[9] = BL_FOUR;
   assign src[10] = ram_size_vld_i && (ram_kb_i < RAM_MIN_KB);
   assign codes[10] = C_RAMSMALL;
   assign blinks[10] = BL_FOUR;
   assign src[11] = reply_vld_i && op_pend_r && (reply_i != ~op_r);
   assign codes[11] = C_NOCOMPL;
   assign blinks[11] = BL_FOUR;
   assign src[12] = slv_tmo_i && (slv_port_i != PORT_EXEMPT);
   assign codes[12] = C_SLVTMO;
   assign blinks[12] = BL_FOUR;
   assign src[13] = sess_done_i && priv_flag_i;
   assign codes[13] = C_PRIV;
   assign blinks[13] = BL_FOUR;

   ////////////////////////////////////////////////////////////////////////
   // Priority pick
   logic [11:0] pick_code [NSRC+1];
   logic [2:0] pick_bl [NSRC+1];
   logic any_src;
   assign pick_code[NSRC] = 12'h000;
   assign pick_bl[NSRC] = BL_STEADY;
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_pick
         assign pick_code[gi] = src[gi] ? codes[gi] : pick_code[gi+1];
         assign pick_bl[gi] = src[gi] ? blinks[gi] : pick_bl[gi+1];
      end
   endgenerate
   assign any_src = |src;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_o <= 1'b0;
         fault_code_o <= 12'h000;
         fault_blinks_o <= BL_STEADY;
      end else if (ce_i && any_src && !fault_o) begin
         fault_o <= 1'b1;
         fault_code_o <= pick_code[0];
         fault_blinks_o <= pick_bl[0];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ready_led_o <= 1'b0;
      end else if (ce_i) begin
         ready_led_o <= diag_done_i && !fault_o && !any_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Blink engine
   bcr_bst_t st_r;
   logic [31:0] tcnt_r;
   logic [2:0] bcnt_r;
   logic tdone;
   assign tdone = (st_r == BST_PAUSE) ? (tcnt_r >= PAUSE_CYC - 1)
                                      : (tcnt_r >= HALF_CYC - 1);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= BST_IDLE;
         tcnt_r <= '0;
         bcnt_r <= 3'h0;
         run_led_o <= 1'b0;
      end else if (ce_i) begin
         tcnt_r <= tdone ? '0 : tcnt_r + 32'h1;
         case (st_r)
            BST_IDLE: begin
               tcnt_r <= '0;
               bcnt_r <= 3'h0;
               run_led_o <= fault_o && (fault_blinks_o == BL_STEADY);
               if (fault_o && fault_blinks_o != BL_STEADY) begin
                  st_r <= BST_ON;
                  run_led_o <= 1'b1;
               end
            end
            BST_ON: if (tdone) begin
               st_r <= BST_OFF;
               run_led_o <= 1'b0;
               bcnt_r <= bcnt_r + 3'h1;
            end
            BST_OFF: if (tdone) begin
               if (bcnt_r == fault_blinks_o) begin
                  st_r <= BST_PAUSE;
               end else begin
                  st_r <= BST_ON;
                  run_led_o <= 1'b1;
               end
            end
            BST_PAUSE: if (tdone) begin
               st_r <= BST_ON;
               bcnt_r <= 3'h0;
               run_led_o <= 1'b1;
            end
            default: st_r <= BST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Network duplication and bridge
   logic ser_net;
   logic ser_loc;
   assign ser_net = bridge_en_i && ser_vld_i && !ser_to_local_i;
   assign ser_loc = bridge_en_i && ser_vld_i && ser_to_local_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         net_a_vld_o <= 1'b0;
         net_b_vld_o <= 1'b0;
         net_a_data_o <= 8'h00;
         net_b_data_o <= 8'h00;
         rx_path_o <= 2'h0;
         loc_vld_o <= 1'b0;
         loc_data_o <= 8'h00;
      end else if (ce_i) begin
         net_a_vld_o <= tx_vld_i || ser_net;
         net_b_vld_o <= tx_vld_i || ser_net;
         net_a_data_o <= tx_vld_i ? tx_data_i : ser_data_i;
         net_b_data_o <= tx_vld_i ? tx_data_i : ser_data_i;
         if (rx_a_vld_i || rx_b_vld_i) begin
            rx_path_o <= {rx_b_vld_i, rx_a_vld_i};
         end
         loc_vld_o <= ser_loc;
         loc_data_o <= ser_data_i;
      end
   end
endmodule // bcr_reporter
`default_nettype wire

// ### tb/bcr_reporter_checker.sv
// Checker for the blink code fault reporter, bound to its top ports.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none
module bcr_reporter_checker
   import bcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic pwrdn_i,
   input wire logic diag_done_i,
   input wire logic port_set_i,
   input wire logic [4:0] port_num_i,
   input wire logic tx_vld_i,
   input wire logic [7:0] tx_data_i,
   input wire logic run_led_o,
   input wire logic ready_led_o,
   input wire logic fault_o,
   input wire logic [11:0] fault_code_o,
   input wire logic [2:0] fault_blinks_o,
   input wire logic net_a_vld_o,
   input wire logic net_b_vld_o,
   input wire logic [7:0] net_a_data_o,
   input wire logic [7:0] net_b_data_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////
   chk_fault_held: assert property (
      fault_o |=> fault_o && $stable(fault_code_o) && $stable(fault_blinks_o))
      else $error("latched fault changed");
   chk_blink_on: assert property (
      $rose(run_led_o) && fault_blinks_o != BL_STEADY |-> run_led_o[*4])
      else $error("blink on phase too short");
   chk_pwrdn_code: assert property (
      ce_i && !fault_o && pwrdn_i |=>
      fault_code_o == C_PWRDN && fault_blinks_o == BL_STEADY)
      else $error("power-down code wrong");
   chk_steady_run: assert property (
      ce_i && fault_o && fault_blinks_o == BL_STEADY |=> run_led_o)
      else $error("steady light off");
   chk_port_limit: assert property (
      ce_i && port_set_i && port_num_i > PORT_MAX |=> fault_o)
      else $error("port above limit not flagged");
   chk_net_dup: assert property (
      ce_i && tx_vld_i |=> net_a_vld_o && net_b_vld_o &&
      net_a_data_o == $past(tx_data_i) && net_b_data_o == $past(tx_data_i))
      else $error("ports differ");
   chk_ready_diag: assert property (
      ce_i && !diag_done_i |=> !ready_led_o) else $error("early ready");
   chk_blink_off: assert property (
      $fell(run_led_o) && fault_blinks_o != BL_STEADY |-> !run_led_o[*4])
      else $error("blink off phase too short");
endmodule // bcr_reporter_checker
bind bcr_reporter bcr_reporter_checker u_bcr_reporter_checker (.*);
`default_nettype wire

// ### tb/bcr_host_model.sv
// Host and peer model: acknowledges requests and answers opcodes.
// Assumes delay and fault choices come from the testbench.
`default_nettype none
module bcr_host_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic op_sent_i,
   input wire logic [7:0] op_i,
   input wire logic [7:0] ack_dly_i,
   input wire logic bad_reply_i,
   output logic ack_o,
   output logic reply_vld_o,
   output logic [7:0] reply_o
);
   logic [7:0] cnt_r;
   ////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {cnt_r, ack_o, reply_vld_o, reply_o} <= '0;
      end else begin
         ack_o <= cnt_r == 8'h01;
         cnt_r <= req_i ? ack_dly_i : cnt_r - 8'(cnt_r != 8'h00);
         reply_vld_o <= op_sent_i;
         reply_o <= op_sent_i ? (bad_reply_i ? op_i : ~op_i) : ~reply_o;
      end
   end
endmodule // bcr_host_model
`default_nettype wire

// ### tb/tb.sv
// Testbench for the blink code fault reporter with host model.
// Assumes counts cut to ack 20, blink half 4, pause 12 cycles.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bcr_pkg::*;
   logic clk_i = '0, rstn_i = '0, ce_i = '1, diag_done_i = '1, pwrdn_i = '0;
   logic ramseq_err_i = '0, ramaddr_err_i = '0, ramdata_err_i = '0;
   logic prom_err_i = '0, loop1_err_i = '0, parity_err_i = '0, req_i = '0;
   logic underflow_i = '0, port_set_i = '0, ram_size_vld_i = '0, bad = '0;
   logic op_sent_i = '0, slv_tmo_i = '0, sess_done_i = '0, priv_flag_i = '0;
   logic tx_vld_i = '0, rx_a_vld_i = '0, rx_b_vld_i = '0, bridge_en_i = '0;
   logic ser_vld_i = '0, ser_to_local_i = '0, ack_i, reply_vld_i, run_led_o;
   logic ready_led_o, fault_o, net_a_vld_o, net_b_vld_o, loc_vld_o;
   logic [4:0] port_num_i = '0, slv_port_i = '0;
   logic [15:0] ram_kb_i = 16'h0040;
   logic [7:0] op_i = '0, tx_data_i = '0, ser_data_i = '0, dly = 8'h05;
   logic [7:0] reply_i, net_a_data_o, net_b_data_o, loc_data_o;
   logic [11:0] fault_code_o;
   logic [2:0] fault_blinks_o;
   logic [1:0] rx_path_o;
   int errors = 0, tests_run = 0, cyc = 0, n;
   bcr_reporter #(.ACK_CYC(20), .HALF_CYC(4), .PAUSE_CYC(12))
      u_bcr_reporter (.*);
   bcr_host_model u_bcr_host_model (.clk_i(clk_i), .rstn_i(rstn_i),
      .req_i(req_i), .op_sent_i(op_sent_i), .op_i(op_i), .ack_dly_i(dly),
      .bad_reply_i(bad), .ack_o(ack_i), .reply_vld_o(reply_vld_i),
      .reply_o(reply_i));
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic idle();
      {pwrdn_i, ramseq_err_i, ramaddr_err_i, ramdata_err_i, prom_err_i,
         loop1_err_i, parity_err_i, underflow_i, req_i, port_set_i, op_sent_i,
         ram_size_vld_i, slv_tmo_i, sess_done_i, tx_vld_i, rx_a_vld_i,
         rx_b_vld_i, ser_vld_i} <= '0;
   endtask
   task automatic rst();
      @(posedge clk_i);
      {rstn_i, priv_flag_i, bad} <= '0;
      idle();
      repeat (2) @(posedge clk_i);
      rstn_i <= '1;
      @(posedge clk_i);
   endtask
   task automatic step(input int w);
      @(posedge clk_i);
      idle();
      repeat (w) @(negedge clk_i);
   endtask
   // Ready waits for diagnostics; limits kept quiet
   task automatic t_quiet();
      diag_done_i <= '0;
      rst();
      step(1);
      chk(ready_led_o, 1'h0);
      @(posedge clk_i);
      {diag_done_i, port_set_i, port_num_i, ram_size_vld_i} <= 8'hEB;
      {ram_kb_i, slv_tmo_i, slv_port_i} <= {16'h0008, 6'h29};
      {sess_done_i, req_i, op_sent_i, op_i} <= {3'h7, 8'h5A};
      step(30);
      chk(fault_o, 1'h0);
      chk(ready_led_o, 1'h1);
   endtask
   task automatic t_faults();
      logic [11:0] cd [12] = '{C_PWRDN, C_RAMSEQ, C_RAMADDR, C_RAMDATA,
         C_PROM, C_LOOP1, C_PARITY, C_UNDER, C_PORTBIG, C_RAMSMALL,
         C_SLVTMO, C_PRIV};
      logic [2:0] bl [12] = '{BL_STEADY, BL_TWO, BL_FIVE, BL_SIX, BL_SEVEN,
         BL_FOUR, BL_FOUR, BL_FOUR, BL_FOUR, BL_FOUR, BL_FOUR, BL_FOUR};
      for (int i = 0; i < 12; i++) begin
         rst();
         {pwrdn_i, ramseq_err_i, ramaddr_err_i, ramdata_err_i, prom_err_i,
            loop1_err_i, parity_err_i, underflow_i} <= 8'(8'h80 >> i);
         {port_set_i, port_num_i, ram_size_vld_i} <= {i == 8, 5'h16, i == 9};
         {ram_kb_i, slv_tmo_i, slv_port_i} <= {16'h0007, i == 10, 5'h03};
         {sess_done_i, priv_flag_i} <= {2{i == 11}};
         step(1);
         chk({fault_o, ready_led_o}, 2'h2);
         chk(fault_code_o, cd[i]);
         chk(fault_blinks_o, bl[i]);
      end
   endtask
   task automatic t_peer();
      rst();
      {dly, req_i} <= {8'h28, 1'h1};
      step(20);
      chk(fault_o, 1'h0);
      @(negedge clk_i);
      chk({fault_code_o, fault_blinks_o}, {C_ACKTMO, BL_THREE});
      rst();
      {bad, op_sent_i, op_i} <= {2'h3, 8'hC3};
      step(3);
      chk({fault_code_o, fault_blinks_o}, {C_NOCOMPL, BL_FOUR});
   endtask
   // Five blinks per sequence, steady class
   task automatic t_blink(input int pwr);
      logic p;
      rst();
      {pwrdn_i, ramaddr_err_i} <= pwr ? 2'h2 : 2'h1;
      step(1);
      {n, p} = '0;
      repeat (112) begin
         @(negedge clk_i);
         n += pwr ? int'(run_led_o === '1) : int'(run_led_o === '1 && !p);
         p = run_led_o;
      end
      chk(12'(n), pwr ? 12'h070 : 12'h00B);
   endtask
   task automatic t_net();
      rst();
      {tx_vld_i, tx_data_i, rx_a_vld_i} <= {1'h1, 8'hA5, 1'h1};
      step(1);
      chk({net_a_vld_o, net_b_vld_o, net_a_data_o}, 12'h3A5);
      chk({net_b_data_o, rx_path_o}, 10'h295);
      @(posedge clk_i);
      {rx_b_vld_i, bridge_en_i, ser_vld_i, ser_to_local_i} <= 4'hF;
      ser_data_i <= 8'h3C;
      step(1);
      chk({rx_path_o, loc_vld_o, loc_data_o, net_a_vld_o}, 12'hA78);
      @(posedge clk_i);
      {ser_vld_i, ser_to_local_i} <= 2'h2;
      step(1);
      chk({net_a_vld_o, net_b_vld_o, net_a_data_o}, 12'h33C);
      @(posedge clk_i);
      {bridge_en_i, ser_vld_i} <= 2'h1;
      step(1);
      chk({net_a_vld_o, loc_vld_o}, 2'h0);
      // Clock enable low must freeze the port outputs
      @(posedge clk_i);
      {ce_i, tx_vld_i} <= 2'h1;
      step(1);
      chk({net_a_vld_o, net_b_vld_o}, 2'h0);
      @(posedge clk_i);
      ce_i <= '1;
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= '1;
      @(posedge clk_i);
      t_quiet();
      t_faults();
      t_peer();
      t_blink(0);
      t_blink(1);
      t_net();
      finish_test();
   end
endmodule // tb
`default_nettype wire
